// ===== afrc_pkg.sv
// Summary of operation
// (RL1) Flag bits 7-5 read as zero
// (RL2) Negative flag follows result MSB
// (RL3) Overflow flag marks signed wrap
// (RL4) Zero flag set on zero result
// (RL5) Nibble carry from bit 3 on add/sub
// (RL6) Carry from bit 7 on add/sub
// (RL7) Subtract adds two's complement of operand
// (RL8) Carry reads zero when borrow occurred
// (RL9) Rotates load nibble carry from bit 4/3
// (RL10) Carry rotates load source end bit
// (RL11) Reset cause flags readable and writable
// (RL12) Priority enable bit 7, resets to zero
// (RL13) Reset-instruction flag cleared by that reset
// (RL14) Watchdog flag cleared by expiry, set by watchdog clear, sleep or power-on
// (RL15) Sleep flag cleared by sleep instruction
// (RL16) Power-up flag zero after power-on reset
// (RL17) Brown-out flag zero after brown-out reset
// (RL18) Brown-out flag one at power-on if enabled
// (RL19) Software sets power-up flag after detection
// (RL20) Computed flags override writes to flags
// (RL21) Long write enable cleared only by reset
// (RL22) Untouched cause flags keep their values
package afrc_pkg;
  localparam logic [31:0] ADDR_FLAGS  = 32'h0000_0000;
  localparam logic [31:0] ADDR_CAUSE  = 32'h0000_0004;
  localparam int          FLAG_N      = 4;
  localparam int          FLAG_OV     = 3;
  localparam int          FLAG_Z      = 2;
  localparam int          FLAG_DC     = 1;
  localparam int          FLAG_C      = 0;
  localparam int          CAUSE_IRQ_PRIORITY_ENABLE  = 7;
  localparam int          CAUSE_LWE   = 6;
  localparam int          CAUSE_RI    = 4;
  localparam int          CAUSE_WDT   = 3;
  localparam int          CAUSE_SLP   = 2;
  localparam int          CAUSE_POR   = 1;
  localparam int          CAUSE_BOR   = 0;
  localparam logic [4:0]  FLAGS_RST   = 5'h00;
  localparam logic [7:0]  CAUSE_WMASK = 8'hDF;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    AFRC_OP_NONE, AFRC_OP_ADD_REG, AFRC_OP_ADD_LIT, AFRC_OP_SUB_REG, AFRC_OP_SUB_LIT,
    AFRC_OP_LOGIC, AFRC_OP_RR_CARRY, AFRC_OP_RR_PLAIN, AFRC_OP_RL_CARRY, AFRC_OP_RL_PLAIN
  } afrc_op_t;
endpackage : afrc_pkg

// ===== afrc_regs.sv
`timescale 1ns/1ps
module afrc_regs (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [31:0] s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  // AXI4-Lite read
  input  wire logic [31:0] s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // ALU result, one-cycle strobe with operands
  input  wire logic        alu_valid,
  input  wire logic [3:0]  alu_op,
  input  wire logic [7:0]  alu_a,
  input  wire logic [7:0]  alu_b,
  input  wire logic [7:0]  alu_logic_res,
  // Reset events and ops, one-cycle pulses; brown-out detect enable is a level
  input  wire logic        por_event,
  input  wire logic        bor_event,
  input  wire logic        master_clear_pin_event,
  input  wire logic        soft_reset_event,
  input  wire logic        watchdog_expiry_event,
  input  wire logic        watchdog_clear_op,
  input  wire logic        sleep_op,
  input  wire logic        brownout_detect_enable,
  // Outputs to consumers
  output logic [7:0]       alu_result,
  output logic [4:0]       alu_flags,
  output logic             irq_priority_enable,
  output logic             long_program_write_enable
);
  logic [7:0] aw_addr_r, cause_r;
  logic       aw_have_r, w_have_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic [4:0] flags_r, flags_nxt;
  logic [7:0] res_nxt;
  logic       flags_wr, cause_wr;
  afrc_pkg::afrc_op_t op;

  assign op = afrc_pkg::afrc_op_t'(alu_op);
  assign s_awready = !aw_have_r && !s_bvalid;
  assign s_wready  = !w_have_r && !s_bvalid;
  assign flags_wr  = aw_have_r && w_have_r && w_strb_r[0] && aw_addr_r == afrc_pkg::ADDR_FLAGS[7:0];
  assign cause_wr  = aw_have_r && w_have_r && w_strb_r[0] && aw_addr_r == afrc_pkg::ADDR_CAUSE[7:0];

  // Write channel capture, address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      s_bvalid  <= 1'b0;
      s_bresp   <= afrc_pkg::RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_awaddr[7:0];
      end
      if (s_wvalid && s_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_wdata;
        w_strb_r <= s_wstrb;
      end
      if (aw_have_r && w_have_r) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        s_bvalid  <= 1'b1;
        s_bresp   <= (aw_addr_r == afrc_pkg::ADDR_FLAGS[7:0] || aw_addr_r == afrc_pkg::ADDR_CAUSE[7:0])
                     ? afrc_pkg::RESP_OKAY : afrc_pkg::RESP_SLVERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // Read channel, one cycle answer; unused flag bits read zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0000_0000;
      s_rresp   <= afrc_pkg::RESP_OKAY;
    end else begin
      s_arready <= !s_rvalid && !s_arready && s_arvalid;
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_rresp  <= afrc_pkg::RESP_OKAY;
        // (RL1) upper zero read
        if (s_araddr[7:0] == afrc_pkg::ADDR_FLAGS[7:0]) s_rdata <= {27'h0, flags_r};
        else if (s_araddr[7:0] == afrc_pkg::ADDR_CAUSE[7:0]) s_rdata <= {24'h0, cause_r};
        else begin
          s_rdata <= 32'h0000_0000;
          s_rresp <= afrc_pkg::RESP_SLVERR;
        end
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // Flag computation from the ALU operation
  always_comb begin
    logic [8:0] sum;
    logic [4:0] lo;
    logic [7:0] b_eff;
    logic       cin;
    sum       = 9'h000;
    lo        = 5'h00;
    b_eff     = alu_b;
    cin       = 1'b0;
    res_nxt   = alu_logic_res;
    flags_nxt = flags_r;
    unique case (op)
      afrc_pkg::AFRC_OP_ADD_REG, afrc_pkg::AFRC_OP_ADD_LIT, afrc_pkg::AFRC_OP_SUB_REG,
      afrc_pkg::AFRC_OP_SUB_LIT: begin
        // (RL7) subtract via complement
        if (op == afrc_pkg::AFRC_OP_SUB_REG || op == afrc_pkg::AFRC_OP_SUB_LIT) begin
          b_eff = ~alu_b;
          cin   = 1'b1;
        end
        sum = {1'b0, alu_a} + {1'b0, b_eff} + {8'h00, cin};
        lo  = {1'b0, alu_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
        res_nxt = sum[7:0];
        // (RL5) nibble carry out
        flags_nxt[afrc_pkg::FLAG_DC] = lo[4];
        // (RL6) (RL8) carry, inverted borrow
        flags_nxt[afrc_pkg::FLAG_C]  = sum[8];
        // (RL3) signed wrap detect
        flags_nxt[afrc_pkg::FLAG_OV] = (alu_a[7] == b_eff[7]) && (sum[7] != alu_a[7]);
      end
      afrc_pkg::AFRC_OP_RR_CARRY, afrc_pkg::AFRC_OP_RR_PLAIN: begin
        res_nxt = {(op == afrc_pkg::AFRC_OP_RR_CARRY) ? flags_r[afrc_pkg::FLAG_C] : alu_a[0], alu_a[7:1]};
        // (RL9) nibble from bit 4
        flags_nxt[afrc_pkg::FLAG_DC] = alu_a[4];
        // (RL10) carry from low bit
        if (op == afrc_pkg::AFRC_OP_RR_CARRY) flags_nxt[afrc_pkg::FLAG_C] = alu_a[0];
      end
      afrc_pkg::AFRC_OP_RL_CARRY, afrc_pkg::AFRC_OP_RL_PLAIN: begin
        res_nxt = {alu_a[6:0], (op == afrc_pkg::AFRC_OP_RL_CARRY) ? flags_r[afrc_pkg::FLAG_C] : alu_a[7]};
        // (RL9) nibble from bit 3
        flags_nxt[afrc_pkg::FLAG_DC] = alu_a[3];
        // (RL10) carry from high bit
        if (op == afrc_pkg::AFRC_OP_RL_CARRY) flags_nxt[afrc_pkg::FLAG_C] = alu_a[7];
      end
      default: res_nxt = alu_logic_res;
    endcase
    if (op != afrc_pkg::AFRC_OP_NONE) begin
      // (RL2) sign of result
      flags_nxt[afrc_pkg::FLAG_N] = res_nxt[7];
      // (RL4) zero result
      flags_nxt[afrc_pkg::FLAG_Z] = (res_nxt == 8'h00);
    end
  end

  // Flag register; an ALU update beats a bus write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_r    <= afrc_pkg::FLAGS_RST;
      alu_result <= 8'h00;
    end else if (alu_valid) begin
      // (RL20) computed flags win
      flags_r    <= flags_nxt;
      alu_result <= res_nxt;
    end else if (flags_wr) begin
      flags_r <= w_data_r[4:0];
    end
  end

  // Reset cause register; events beat software writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // (RL12) priority enable resets low
      cause_r <= 8'h1C;
    end else begin
      // (RL11) (RL22) software write, others hold
      if (cause_wr) cause_r <= (w_data_r[7:0] & afrc_pkg::CAUSE_WMASK)
                               | {1'b0, cause_r[afrc_pkg::CAUSE_LWE] | w_data_r[6], 6'h00};
      // (RL13) soft reset marker
      if (soft_reset_event) cause_r[afrc_pkg::CAUSE_RI] <= 1'b0;
      // (RL14) watchdog flag
      if (watchdog_clear_op || sleep_op) cause_r[afrc_pkg::CAUSE_WDT] <= 1'b1;
      if (watchdog_expiry_event) cause_r[afrc_pkg::CAUSE_WDT] <= 1'b0;
      // (RL15) sleep flag
      if (sleep_op) cause_r[afrc_pkg::CAUSE_SLP] <= 1'b0;
      // (RL21) long write cleared by reset only
      if (master_clear_pin_event) cause_r[afrc_pkg::CAUSE_LWE] <= 1'b0;
      // (RL17) brown-out marker
      if (bor_event) cause_r[afrc_pkg::CAUSE_BOR] <= 1'b0;
      if (por_event) begin
        cause_r <= 8'h1C;
        // (RL16) (RL18) power-on values
        cause_r[afrc_pkg::CAUSE_POR] <= 1'b0;
        cause_r[afrc_pkg::CAUSE_BOR] <= brownout_detect_enable;
      end
    end
  end

  // Outputs registered straight from state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alu_flags                 <= 5'h00;
      irq_priority_enable       <= 1'b0;
      long_program_write_enable <= 1'b0;
    end else begin
      alu_flags                 <= flags_r;
      irq_priority_enable       <= cause_r[afrc_pkg::CAUSE_IRQ_PRIORITY_ENABLE];
      long_program_write_enable <= cause_r[afrc_pkg::CAUSE_LWE];
    end
  end

  sequence sub_op_s;
    alu_valid && (op == afrc_pkg::AFRC_OP_SUB_REG) && (alu_a < alu_b);
  endsequence
  sub_borrow_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL8
    sub_op_s |=> !flags_r[afrc_pkg::FLAG_C]) else $error("borrow did not clear carry");
  zero_flag_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL4
    alu_valid && op != afrc_pkg::AFRC_OP_NONE |=> flags_r[afrc_pkg::FLAG_Z] == (alu_result == 8'h00))
    else $error("zero flag mismatch");
  neg_flag_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL2
    alu_valid && op != afrc_pkg::AFRC_OP_NONE |=> flags_r[afrc_pkg::FLAG_N] == alu_result[7])
    else $error("negative flag mismatch");
  upper_zero_a: assert property (@(posedge aclk) disable iff (!aresetn) // bits 31-8 read zero on every OKAY read; RL1 bits 7-5 not checked here
    s_rvalid && s_rresp == afrc_pkg::RESP_OKAY |-> s_rdata[31:8] == 24'h0) else $error("upper bits nonzero");
  alu_wins_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL20
    alu_valid && flags_wr |=> flags_r == $past(flags_nxt)) else $error("write beat alu");
  lwe_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL21
    cause_r[afrc_pkg::CAUSE_LWE] && !por_event && !master_clear_pin_event |=> cause_r[afrc_pkg::CAUSE_LWE])
    else $error("long write enable dropped");
  wdt_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL14
    watchdog_expiry_event && !por_event |=> !cause_r[afrc_pkg::CAUSE_WDT]) else $error("watchdog flag set");
  por_flag_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL16
    por_event |=> !cause_r[afrc_pkg::CAUSE_POR] ##1 irq_priority_enable == 1'b0) else $error("power-up flag");
  sleep_flag_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL15
    sleep_op && !por_event |=> !cause_r[afrc_pkg::CAUSE_SLP]) else $error("sleep flag not cleared");
endmodule : afrc_regs

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // Bench-driven inputs, all start at a known value
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [31:0] s_awaddr = 32'h0, s_wdata = 32'h0, s_araddr = 32'h0, s_rdata;
  logic [3:0]  s_wstrb = 4'hF, alu_op = 4'h0;
  logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq_pe, lwe;
  logic [1:0]  s_bresp, s_rresp;
  logic        alu_valid = 1'b0, bod_en = 1'b1;
  logic [7:0]  alu_a = 8'h00, alu_b = 8'h00, alu_lres = 8'h80, alu_result;
  logic [4:0]  alu_flags;
  logic [6:0]  ev = 7'h00; // por, bor, master_clear_pin, soft, expiry, wd clear, sleep
  int          bad_count = 0;
  int          comparisons = 0;
  // 200 MHz clock
  always #2.5 aclk = ~aclk;
  afrc_regs i_dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .alu_valid(alu_valid), .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b), .alu_logic_res(alu_lres),
    .por_event(ev[0]), .bor_event(ev[1]), .master_clear_pin_event(ev[2]), .soft_reset_event(ev[3]),
    .watchdog_expiry_event(ev[4]), .watchdog_clear_op(ev[5]), .sleep_op(ev[6]),
    .brownout_detect_enable(bod_en), .alu_result(alu_result), .alu_flags(alu_flags),
    .irq_priority_enable(irq_pe), .long_program_write_enable(lwe));
  task automatic test_done;
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  // Masked four-state compare
  task automatic chk(input string nm, input logic [31:0] e, g, m);
    comparisons++;
    if ((g & m) !== (e & m)) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", nm, e & m, g & m);
    end
  endtask : chk
  // Write: address and data offered together, each released once taken
  task automatic wr_chk(input logic [31:0] a, d, input logic [1:0] er);
    bit aw, w, b;
    {aw, w, b} = 3'b000;
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!b) begin
      @(posedge aclk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      if (s_bvalid) b = 1'b1;
      if (b) chk("bresp", 32'(er), 32'(s_bresp), 32'h3);
    end
    s_bready <= 1'b0;
  endtask : wr_chk
  // Read and compare data and response
  task automatic rd_chk(input string nm, input logic [31:0] a, e, m, input logic [1:0] er);
    bit r;
    r = 1'b0;
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    while (!r) begin
      @(posedge aclk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
      r = s_rvalid;
    end
    s_rready <= 1'b0;
    chk(nm, e, s_rdata, m);
    chk("rresp", 32'(er), 32'(s_rresp), 32'h3);
  endtask : rd_chk
  // One ALU strobe; the flag copy lags the flag register by a cycle
  task automatic alu_do(input logic [3:0] op, input logic [7:0] a, b, r, input logic [4:0] f, m);
    alu_op <= op;
    alu_a <= a;
    alu_b <= b;
    alu_valid <= 1'b1;
    @(posedge aclk);
    alu_valid <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("alu_flags", 32'(f), 32'(alu_flags), 32'(m));
    chk("alu_result", 32'(r), 32'(alu_result), (m == 5'h1F) ? 32'hFF : 32'h0);
    rd_chk("flag_reg", afrc_pkg::ADDR_FLAGS, 32'(f), 32'(m) | 32'hE0, afrc_pkg::RESP_OKAY);
  endtask : alu_do
  // One event pulse, then the cause register
  task automatic ev_do(input int i, input logic [31:0] e, m);
    ev[i] <= 1'b1;
    @(posedge aclk);
    ev <= 7'h00;
    @(posedge aclk);
    rd_chk("cause_reg", afrc_pkg::ADDR_CAUSE, e, m, afrc_pkg::RESP_OKAY);
  endtask : ev_do
  task automatic t_reset;
    rd_chk("flag_reg", afrc_pkg::ADDR_FLAGS, 32'h0, 32'hFF, afrc_pkg::RESP_OKAY);
    rd_chk("cause_reg", afrc_pkg::ADDR_CAUSE, 32'h1C, 32'hFF, afrc_pkg::RESP_OKAY);
  endtask : t_reset
  task automatic t_bus;
    rd_chk("unmapped", 32'h8, 32'h0, 32'hFFFFFFFF, afrc_pkg::RESP_SLVERR);
    wr_chk(32'h8, 32'hFF, afrc_pkg::RESP_SLVERR);
    wr_chk(afrc_pkg::ADDR_FLAGS, 32'hFF, afrc_pkg::RESP_OKAY);
    rd_chk("flag_reg", afrc_pkg::ADDR_FLAGS, 32'h1F, 32'hFF, afrc_pkg::RESP_OKAY);
    s_wstrb <= 4'h0;
    wr_chk(afrc_pkg::ADDR_FLAGS, 32'h0, afrc_pkg::RESP_OKAY);
    s_wstrb <= 4'hF;
    rd_chk("flag_reg", afrc_pkg::ADDR_FLAGS, 32'h1F, 32'hFF, afrc_pkg::RESP_OKAY);
  endtask : t_bus
  // Subtract taken as alu_a minus alu_b
  task automatic t_arith;
    alu_do(afrc_pkg::AFRC_OP_ADD_REG, 8'h0F, 8'h01, 8'h10, 5'h02, 5'h1F);
    alu_do(afrc_pkg::AFRC_OP_ADD_LIT, 8'h7F, 8'h01, 8'h80, 5'h1A, 5'h1F);
    alu_do(afrc_pkg::AFRC_OP_ADD_REG, 8'hFF, 8'h01, 8'h00, 5'h07, 5'h1F);
    alu_do(afrc_pkg::AFRC_OP_SUB_REG, 8'h10, 8'h20, 8'hF0, 5'h12, 5'h1F);
    alu_do(afrc_pkg::AFRC_OP_SUB_LIT, 8'h33, 8'h33, 8'h00, 5'h07, 5'h1F);
    alu_do(afrc_pkg::AFRC_OP_LOGIC, 8'h00, 8'h00, 8'h00, 5'h10, 5'h14);
    alu_lres <= 8'h00;
    alu_do(afrc_pkg::AFRC_OP_LOGIC, 8'h00, 8'h00, 8'h00, 5'h04, 5'h14);
  endtask : t_arith
  // Bits 4 and 3 of each source agree, so either direction gives one nibble carry
  task automatic t_rotate;
    alu_do(afrc_pkg::AFRC_OP_RL_CARRY, 8'h98, 8'h00, 8'h00, 5'h03, 5'h03);
    alu_do(afrc_pkg::AFRC_OP_RR_CARRY, 8'h67, 8'h00, 8'h00, 5'h01, 5'h03);
    alu_do(afrc_pkg::AFRC_OP_RL_CARRY, 8'h67, 8'h00, 8'h00, 5'h00, 5'h03);
    alu_do(afrc_pkg::AFRC_OP_RR_CARRY, 8'h98, 8'h00, 8'h00, 5'h02, 5'h03);
    alu_do(afrc_pkg::AFRC_OP_RR_PLAIN, 8'h98, 8'h00, 8'h00, 5'h02, 5'h02);
    alu_do(afrc_pkg::AFRC_OP_RL_PLAIN, 8'h67, 8'h00, 8'h00, 5'h00, 5'h02);
  endtask : t_rotate
  task automatic t_cause;
    ev_do(4, 32'h14, 32'hFF);
    ev_do(5, 32'h1C, 32'hFF);
    ev_do(6, 32'h18, 32'hFF);
    ev_do(3, 32'h08, 32'hFF);
    wr_chk(afrc_pkg::ADDR_CAUSE, 32'hFF, afrc_pkg::RESP_OKAY);
    rd_chk("cause_reg", afrc_pkg::ADDR_CAUSE, 32'hDF, 32'hFF, afrc_pkg::RESP_OKAY);
    chk("priority_out", 32'h1, 32'(irq_pe), 32'h1);
    chk("long_write_out", 32'h1, 32'(lwe), 32'h1);
    wr_chk(afrc_pkg::ADDR_CAUSE, 32'h0, afrc_pkg::RESP_OKAY);
    rd_chk("cause_reg", afrc_pkg::ADDR_CAUSE, 32'h40, 32'hFF, afrc_pkg::RESP_OKAY);
    ev_do(1, 32'h40, 32'h41);
    ev_do(2, 32'h00, 32'h40);
    wr_chk(afrc_pkg::ADDR_CAUSE, 32'h83, afrc_pkg::RESP_OKAY);
    ev_do(0, 32'h1D, 32'hFF);
    bod_en <= 1'b0;
    wr_chk(afrc_pkg::ADDR_CAUSE, 32'h03, afrc_pkg::RESP_OKAY);
    ev_do(0, 32'h1C, 32'hFE);
  endtask : t_cause
  // Main sequence
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_bus();
    t_arith();
    t_rotate();
    t_cause();
    test_done();
  end
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge aclk);
    bad_count++;
    test_done();
  end
endmodule : tb_top
